// *** hw/sar_region_pick.sv ***
// One region bit picked from a per-region attribute word.
// Assumes the index is already the top effective-address bits.
`timescale 1ns/1ps
module sar_region_pick #(
  parameter int REGIONS = 32,
  parameter int IDX_W = 5
) (
  // Attribute word, bit 0 = lowest region
  input wire logic [REGIONS-1:0] regionBits,
  // Region index
  input wire logic [IDX_W-1:0] regionIndex,
  // Selected attribute
  output logic regionAttr
);

  assign regionAttr = regionBits[regionIndex];

endmodule

// *** hw/sar_resolver.sv ***
// Storage-attribute resolver: per-access attributes and access steering.
// Assumes one core clock, register port strobes never both high, and
// access inputs synchronous to sys_clk.
//
// Contract
// - Write-through 0: store hit updates cache only, miss allocates, no memory.
// - Write-through 1: hit writes cache and memory, miss writes memory only.
// - Virtual mode: inhibit 0 means cacheable, 1 bypasses the cache.
// - Real mode cacheability bits: 1 enables caching, 0 disables it.
// - Coherency attribute is carried but changes nothing.
// - Guarded 1 forbids speculative fetches and loads; guarded 0 allows them.
// - Guarded region: no prefetch, fetch only after earlier instructions finish.
// - Exception enable 1 and user attribute 1: store raises data-storage fault.
// - User attribute never affects fetches or loads; store check still works.
// - Endian attribute 0 big-endian, 1 little-endian.
// - Virtual mode takes attributes from translation entry, ignores registers.
// - Real mode: 32-bit register per attribute, one bit per 128 MB region.
// - Region bit selected by the five top effective-address bits.
// - Relocate bit 0 selects real mode, 1 selects virtual mode.
// - Reset sets every real-mode guarded bit to 1.
// - Reset clears every real-mode data-cache cacheability bit to 0.
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module sar_resolver
  import sar_pkg::*;
#(
  parameter int ADDR_W = EA_W,
  parameter int NREG = REGIONS,
  parameter int IDX_W = REGION_IDX_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [REG_ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  // Interrupt
  output logic irq,
  // Access request
  input wire logic accValid,
  input wire logic accIsFetch,
  input wire logic accIsLoad,
  input wire logic accIsStore,
  input wire logic accSpeculative,
  input wire logic [ADDR_W-1:0] effective_address,
  input wire logic instr_relocate_bit,
  input wire logic priorDone,
  input wire logic cacheHit,
  input wire logic [DATA_W-1:0] storeDataIn,
  // Translation entry attributes
  input wire logic tlbWriteThru,
  input wire logic tlbInhibit,
  input wire logic tlbCoherent,
  input wire logic tlbGuarded,
  input wire logic tlbUserDef,
  input wire logic tlbLittle,
  // Resolved attributes
  output logic attrWriteThru,
  output logic attrInhibit,
  output logic attrCoherent,
  output logic attrGuarded,
  output logic user_defined_attr,
  output logic attrLittle,
  // Access steering
  output logic cacheWrite,
  output logic memWrite,
  output logic allocLine,
  output logic cacheBypass,
  output logic loadIssue,
  output logic fetchIssue,
  output logic prefetchEnable,
  output logic storeFault,
  output logic [DATA_W-1:0] storeDataOut
);

  // ==========================================================
  // Real-mode attribute registers
  logic [NREG-1:0] writeThruBits;
  logic [NREG-1:0] data_cacheable_region_bits;
  logic [NREG-1:0] instr_cacheable_region_bits;
  logic [NREG-1:0] guarded_region_bits;
  logic [NREG-1:0] userDefBits;
  logic [NREG-1:0] littleEndBits;
  logic [CFG_W-1:0] core_config_reg;
  logic [EVT_W-1:0] intStatus;
  logic [EVT_W-1:0] intEnable;
  logic [EVT_W-1:0] evtSet;
  logic [EVT_W-1:0] evtClear;
  logic [DATA_W-1:0] next_regRdData;
  logic user_store_exc_enable;

  assign user_store_exc_enable = core_config_reg[CFG_USER_EXC_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      writeThruBits <= RST_WRITE_THRU;
    end else if (regWrite && regAddr == OFS_WRITE_THRU) begin
      writeThruBits <= regWrData[NREG-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_cacheable_region_bits <= RST_DCACHE_OK;
    end else if (regWrite && regAddr == OFS_DCACHE_OK) begin
      data_cacheable_region_bits <= regWrData[NREG-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      instr_cacheable_region_bits <= RST_ICACHE_OK;
    end else if (regWrite && regAddr == OFS_ICACHE_OK) begin
      instr_cacheable_region_bits <= regWrData[NREG-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      guarded_region_bits <= RST_GUARDED;
    end else if (regWrite && regAddr == OFS_GUARDED) begin
      guarded_region_bits <= regWrData[NREG-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      userDefBits <= RST_USER_DEF;
    end else if (regWrite && regAddr == OFS_USER_DEF) begin
      userDefBits <= regWrData[NREG-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      littleEndBits <= RST_LITTLE_END;
    end else if (regWrite && regAddr == OFS_LITTLE_END) begin
      littleEndBits <= regWrData[NREG-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_config_reg <= RST_CORE_CFG;
    end else if (regWrite && regAddr == OFS_CORE_CFG) begin
      core_config_reg <= regWrData[CFG_W-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      intEnable <= RST_EVT;
    end else if (regWrite && regAddr == OFS_INT_ENABLE) begin
      intEnable <= regWrData[EVT_W-1:0];
    end
  end

  // ==========================================================
  // Region selection
  logic [IDX_W-1:0] regionIndex;
  logic [NREG-1:0] regionWord [6];
  logic [5:0] regionAttr;
  logic realMode;

  // Top address bits are the region number, bit 0 = lowest 128 MB
  assign regionIndex = effective_address[ADDR_W-1 -: IDX_W];
  assign realMode = ~instr_relocate_bit;

  assign regionWord[0] = writeThruBits;
  assign regionWord[1] = data_cacheable_region_bits;
  assign regionWord[2] = instr_cacheable_region_bits;
  assign regionWord[3] = guarded_region_bits;
  assign regionWord[4] = userDefBits;
  assign regionWord[5] = littleEndBits;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_pick
      sar_region_pick #(
        .REGIONS(NREG),
        .IDX_W(IDX_W)
      ) u_pick (
        .regionBits(regionWord[gi]),
        .regionIndex(regionIndex),
        .regionAttr(regionAttr[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Attribute resolution, combinational so no extra stall cycle
  logic cacheable;
  logic realCacheable;

  // Fetches use the instruction-side word, data accesses the data side
  assign realCacheable = accIsFetch ? regionAttr[2] : regionAttr[1];

  always_comb begin
    if (realMode) begin
      attrWriteThru = regionAttr[0];
      cacheable = realCacheable;
      attrGuarded = regionAttr[3];
      user_defined_attr = regionAttr[4];
      attrLittle = regionAttr[5];
      attrCoherent = 1'b0;
    end else begin
      // Registers ignored entirely in virtual mode
      attrWriteThru = tlbWriteThru;
      cacheable = ~tlbInhibit;
      attrGuarded = tlbGuarded;
      user_defined_attr = tlbUserDef;
      attrLittle = tlbLittle;
      attrCoherent = tlbCoherent;
    end
  end

  assign attrInhibit = ~cacheable;

  // ==========================================================
  // Store steering
  logic doStore;

  // User attribute only gates stores; fetches and loads never see it
  assign storeFault = accValid & accIsStore & user_store_exc_enable
                    & user_defined_attr;
  assign doStore = accValid & accIsStore & ~storeFault;

  // Write-back hits and misses stay in the cache
  assign cacheWrite = doStore & cacheable
                    & (~attrWriteThru | cacheHit);
  assign allocLine = doStore & cacheable & ~attrWriteThru
                   & ~cacheHit;
  assign memWrite = doStore & (~cacheable | attrWriteThru);
  assign cacheBypass = accValid & ~cacheable;

  // ==========================================================
  // Speculation control
  logic specAllowed;
  logic guardHold;

  assign specAllowed = ~accSpeculative | ~attrGuarded;
  assign loadIssue = accValid & accIsLoad & specAllowed;
  // Guarded fetches wait for the pipe to drain; costly but never speculative
  assign fetchIssue = accValid & accIsFetch & specAllowed
                    & (~attrGuarded | priorDone);
  assign prefetchEnable = ~attrGuarded;
  assign guardHold = accValid & accIsFetch & attrGuarded & ~priorDone;

  // ==========================================================
  // Byte ordering
  function automatic logic [DATA_W-1:0] swapBytes(
    input logic [DATA_W-1:0] din
  );
    logic [DATA_W-1:0] dout;
    dout = '0;
    for (int b = 0; b < DATA_W / 8; b++) begin
      dout[b*8 +: 8] = din[DATA_W-8-b*8 +: 8];
    end
    return dout;
  endfunction

  // Bus is big-endian; little-endian regions get their lanes reversed
  assign storeDataOut = attrLittle ? swapBytes(storeDataIn)
                                   : storeDataIn;

  // ==========================================================
  // Event status, set wins over clear
  assign evtSet[EVT_USER_STORE] = storeFault;
  // Flags the undefined case; result of that access is not guaranteed
  assign evtSet[EVT_INHIBIT_HIT] = accValid & ~cacheable & cacheHit;
  assign evtSet[EVT_GUARD_HOLD] = guardHold;
  assign evtClear = (regWrite && regAddr == OFS_INT_CLEAR)
                  ? regWrData[EVT_W-1:0] : RST_EVT;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      intStatus <= RST_EVT;
    end else begin
      intStatus <= (intStatus & ~evtClear) | evtSet;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((intStatus & ~evtClear) | evtSet) & intEnable);
    end
  end

  // ==========================================================
  // Read path, data one cycle after the strobe
  always_comb begin
    next_regRdData = '0;
    if (regRead) begin
      case (regAddr)
        OFS_WRITE_THRU: next_regRdData[NREG-1:0] = writeThruBits;
        OFS_DCACHE_OK:
          next_regRdData[NREG-1:0] = data_cacheable_region_bits;
        OFS_ICACHE_OK:
          next_regRdData[NREG-1:0] = instr_cacheable_region_bits;
        OFS_GUARDED: next_regRdData[NREG-1:0] = guarded_region_bits;
        OFS_USER_DEF: next_regRdData[NREG-1:0] = userDefBits;
        OFS_LITTLE_END: next_regRdData[NREG-1:0] = littleEndBits;
        OFS_CORE_CFG: next_regRdData[CFG_W-1:0] = core_config_reg;
        OFS_INT_STATUS: next_regRdData[EVT_W-1:0] = intStatus;
        OFS_INT_ENABLE: next_regRdData[EVT_W-1:0] = intEnable;
        default: next_regRdData = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else begin
      regRdData <= next_regRdData;
    end
  end

endmodule

// *** inc/sar_pkg.sv ***
// Constants shared by the storage-attribute resolver.
// Assumes a byte-addressed register port with one 32-bit word per register.
package sar_pkg;

  // ==========================================================
  // Address and region geometry
  localparam int EA_W = 32;
  localparam int REGIONS = 32;
  localparam int REGION_IDX_W = 5;
  localparam int DATA_W = 32;
  localparam int REG_ADDR_W = 8;

  // ==========================================================
  // Register byte offsets
  localparam logic [REG_ADDR_W-1:0] OFS_WRITE_THRU = 8'h00;
  localparam logic [REG_ADDR_W-1:0] OFS_DCACHE_OK = 8'h04;
  localparam logic [REG_ADDR_W-1:0] OFS_ICACHE_OK = 8'h08;
  localparam logic [REG_ADDR_W-1:0] OFS_GUARDED = 8'h0c;
  localparam logic [REG_ADDR_W-1:0] OFS_USER_DEF = 8'h10;
  localparam logic [REG_ADDR_W-1:0] OFS_LITTLE_END = 8'h14;
  localparam logic [REG_ADDR_W-1:0] OFS_CORE_CFG = 8'h18;
  localparam logic [REG_ADDR_W-1:0] OFS_INT_STATUS = 8'h1c;
  localparam logic [REG_ADDR_W-1:0] OFS_INT_CLEAR = 8'h20;
  localparam logic [REG_ADDR_W-1:0] OFS_INT_ENABLE = 8'h24;

  // ==========================================================
  // Reset values
  localparam logic [REGIONS-1:0] RST_WRITE_THRU = 32'h0000_0000;
  localparam logic [REGIONS-1:0] RST_DCACHE_OK = 32'h0000_0000;
  localparam logic [REGIONS-1:0] RST_ICACHE_OK = 32'h0000_0000;
  localparam logic [REGIONS-1:0] RST_GUARDED = 32'hffff_ffff;
  localparam logic [REGIONS-1:0] RST_USER_DEF = 32'h0000_0000;
  localparam logic [REGIONS-1:0] RST_LITTLE_END = 32'h0000_0000;

  // ==========================================================
  // Field layouts
  localparam int CFG_W = 1;
  localparam int CFG_USER_EXC_BIT = 0;
  localparam logic [CFG_W-1:0] RST_CORE_CFG = 1'h0;

  localparam int EVT_W = 3;
  localparam int EVT_USER_STORE = 0;
  localparam int EVT_INHIBIT_HIT = 1;
  localparam int EVT_GUARD_HOLD = 2;
  localparam logic [EVT_W-1:0] RST_EVT = 3'h0;

endpackage

// *** test/sar_cache_model.sv ***
// Behavioural cache-tag model on the core side of the resolver.
// One valid flag per 128 MB region: coarse, but hits follow allocation.
`timescale 1ns/1ps
module sar_cache_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Access side
  input wire logic flush,
  input wire logic [31:0] effective_address,
  input wire logic allocLine,
  // Lookup result
  output logic cacheHit
);
  logic [31:0] lineValid;
  assign cacheHit = lineValid[effective_address[31:27]];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lineValid <= '0;
    end else if (flush) begin
      lineValid <= '0;
    end else if (allocLine) begin
      lineValid[effective_address[31:27]] <= 1'b1;
    end
  end
endmodule

// *** test/sar_props.sv ***
// Port-level assertions for the storage-attribute resolver.
// Bound to sar_resolver from the bench; one clock, async reset.
`timescale 1ns/1ps
module sar_props
  import sar_pkg::*;
(
  // Clock, reset, read data
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic regRead,
  input wire logic [DATA_W-1:0] regRdData,
  // Access inputs
  input wire logic accValid,
  input wire logic accIsFetch,
  input wire logic accIsLoad,
  input wire logic accIsStore,
  input wire logic accSpeculative,
  input wire logic priorDone,
  input wire logic cacheHit,
  input wire logic [DATA_W-1:0] storeDataIn,
  // Resolved outputs
  input wire logic attrWriteThru,
  input wire logic attrInhibit,
  input wire logic attrGuarded,
  input wire logic attrLittle,
  input wire logic user_defined_attr,
  input wire logic cacheWrite,
  input wire logic memWrite,
  input wire logic allocLine,
  input wire logic cacheBypass,
  input wire logic loadIssue,
  input wire logic fetchIssue,
  input wire logic prefetchEnable,
  input wire logic storeFault,
  input wire logic [DATA_W-1:0] storeDataOut
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Store that is neither faulted nor inhibited
  wire st = accValid && accIsStore && !storeFault && !attrInhibit;
  // ========
  // Assertions
  wb_miss_a: assert property (
    st && !attrWriteThru && !cacheHit |-> cacheWrite && allocLine && !memWrite)
    else $error("write-back miss steering wrong");
  wt_store_a: assert property (
    st && attrWriteThru |-> memWrite && !allocLine && cacheWrite == cacheHit)
    else $error("write-through steering wrong");
  inhibit_bypass_a: assert property (
    accValid && attrInhibit |-> cacheBypass)
    else $error("inhibited access not bypassed");
  guard_load_a: assert property (
    accValid && accIsLoad && accSpeculative && attrGuarded |-> !loadIssue)
    else $error("speculative guarded load issued");
  guard_fetch_a: assert property (
    accValid && accIsFetch && attrGuarded && !priorDone
    |-> !fetchIssue && !prefetchEnable)
    else $error("guarded fetch issued early");
  fault_src_a: assert property (
    storeFault |-> accIsStore && user_defined_attr)
    else $error("fault without user store");
  fault_kill_a: assert property (
    storeFault |-> !cacheWrite && !memWrite && !allocLine)
    else $error("faulted store not suppressed");
  endian_swap_a: assert property (
    accValid && accIsStore |-> storeDataOut ==
    (attrLittle ? {storeDataIn[7:0], storeDataIn[15:8], storeDataIn[23:16],
    storeDataIn[31:24]} : storeDataIn))
    else $error("store byte order wrong");
  rd_idle_a: assert property (!regRead |=> regRdData == '0)
    else $error("read data outside read slot");
  cover property (storeFault);
  cover property (st && attrWriteThru && cacheHit);
  cover property (accValid && accIsFetch && attrGuarded && !priorDone);
endmodule

// *** test/test_storage_attribute_resolver.sv ***
// Self-checking bench for the storage-attribute resolver.
// Drives registers and accesses; the cache model answers hits.
`timescale 1ns/1ps
module test_storage_attribute_resolver;
  import sar_pkg::*;
  // ========
  // Signals
  logic sys_clk, rst_n, regWrite, regRead, irq, flush, rdPend;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, storeDataIn, storeDataOut, ed;
  logic [31:0] effective_address;
  logic accValid, accIsFetch, accIsLoad, accIsStore, accSpeculative;
  logic instr_relocate_bit, priorDone, cacheHit;
  logic tlbWriteThru, tlbInhibit, tlbCoherent, tlbGuarded, tlbUserDef;
  logic tlbLittle, attrWriteThru, attrInhibit, attrCoherent, attrGuarded;
  logic user_defined_attr, attrLittle, cacheWrite, memWrite, allocLine;
  logic cacheBypass, loadIssue, fetchIssue, prefetchEnable, storeFault;
  logic [4:0] ex;
  logic [5:0] tl;
  int failures = 0;
  int comparisons = 0;
  logic [31:0] expQ[$];
  logic [31:0] regs[6];
  logic [7:0] ofs[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20,
    8'h3c};
  logic [3:0] stp[5] = '{4'ha, 4'ha, 4'h5, 4'h4, 4'he};
  wire [5:0] va = {attrWriteThru, attrInhibit, attrCoherent, attrGuarded,
    user_defined_attr, attrLittle};
  wire [2:0] steer = {cacheWrite, memWrite, allocLine};
  sar_resolver u_dut (.*);
  sar_cache_model u_cache (.*);
  // ========
  // Tasks
  task automatic chk(input string n, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regRead <= 1'b0;
    regWrite <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    expQ.push_back(e);
    regAddr <= a;
    regWrite <= 1'b0;
    regRead <= 1'b1;
  endtask
  task automatic nop();
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regRead <= 1'b0;
    #5;
  endtask
  // Access kind k is {fetch, load, store}; 0 idles the port
  task automatic acc(input logic [2:0] k, input logic sp, pd,
    input logic [31:0] a, input logic [5:0] t);
    @(posedge sys_clk);
    {accIsFetch, accIsLoad, accIsStore} <= k;
    accValid <= |k;
    accSpeculative <= sp;
    priorDone <= pd;
    effective_address <= a;
    storeDataIn <= $urandom();
    {tlbWriteThru, tlbInhibit, tlbCoherent, tlbGuarded, tlbUserDef,
      tlbLittle} <= t;
    flush <= 1'b0;
    #5;
  endtask
  function automatic logic [31:0] bswap(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ========
  // Clock, read monitor, watchdog
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (rdPend) begin
      chk("read data", expQ.pop_front(), regRdData);
    end
    rdPend <= regRead;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    end_of_test();
  end
  // ========
  // Tests
  initial begin
    void'($urandom(48));
    {regWrite, regRead, accValid, accIsFetch, accIsLoad, accIsStore} = '0;
    {accSpeculative, instr_relocate_bit, priorDone, flush, rdPend} = '0;
    {tlbWriteThru, tlbInhibit, tlbCoherent, tlbGuarded, tlbUserDef} = '0;
    tlbLittle = 1'b0;
    regAddr = '0;
    regWrData = '0;
    storeDataIn = '0;
    effective_address = '0;
    rst_n = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (ofs[i]) rd(ofs[i], i == 3 ? 32'hffff_ffff : 32'h0);
    nop();
    acc(3'b010, 1'b1, 1'b0, 32'h8000_0000, 6'h0);
    chk("reset attrs", 32'h6, {attrInhibit, attrGuarded, loadIssue});
    $display("test reset done");
    for (int r = 0; r < 6; r++) begin
      regs[r] = $urandom();
      wr(ofs[r], regs[r]);
    end
    for (int r = 0; r < 6; r++) rd(ofs[r], regs[r]);
    nop();
    for (int i = 0; i < 32; i++) begin
      acc(3'b100, 1'b0, 1'b1, {i[4:0], 27'($urandom())}, 6'h0);
      chk("fetch inhibit", 32'(!regs[2][i]), 32'(attrInhibit));
      acc(3'b001, 1'b0, 1'b1, {i[4:0], 27'h0}, 6'h0);
      ex = {regs[0][i], !regs[1][i], regs[3][i], regs[4][i], regs[5][i]};
      chk("real attrs", 32'(ex), 32'({va[5:4], va[2:0]}));
      ed = regs[5][i] ? bswap(storeDataIn) : storeDataIn;
      chk("store data", ed, storeDataOut);
    end
    $display("test real mode done");
    @(posedge sys_clk);
    flush <= 1'b1;
    instr_relocate_bit <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      tl = 6'($urandom());
      acc(3'b010, 1'b0, 1'b1, $urandom(), tl);
      chk("virt attrs", 32'(tl), 32'(va));
      chk("bypass", 32'(tl[4]), 32'(cacheBypass));
    end
    @(posedge sys_clk);
    flush <= 1'b1;
    foreach (stp[j]) begin
      acc(3'b001, 1'b0, 1'b1, 32'h4000_0100, {stp[j][3], 5'h0});
      chk("steer", 32'(stp[j][2:0]), 32'(steer));
    end
    // Inhibited load onto the line just allocated: flagged, not defined
    acc(3'b010, 1'b0, 1'b1, 32'h4000_0100, 6'h10);
    chk("inhibit bypass", 32'h1, 32'(cacheBypass));
    rd(8'h1c, 32'h2);
    nop();
    $display("test virtual mode done");
    @(posedge sys_clk);
    flush <= 1'b1;
    accValid <= 1'b0;
    instr_relocate_bit <= 1'b0;
    wr(8'h10, 32'hffff_ffff);
    wr(8'h18, 32'h1);
    wr(8'h24, 32'h1);
    wr(8'h20, 32'h7);
    nop();
    acc(3'b001, 1'b0, 1'b1, 32'hf800_0000, 6'h0);
    chk("fault", 32'h1, 32'(storeFault));
    chk("fault steer", 32'h0, 32'(steer));
    acc(3'b000, 1'b0, 1'b1, 32'h0, 6'h0);
    chk("irq set", 32'h1, 32'(irq));
    rd(8'h1c, 32'h1);
    wr(8'h20, 32'h1);
    nop();
    chk("irq clear", 32'h0, 32'(irq));
    wr(8'h24, 32'h0);
    nop();
    acc(3'b001, 1'b0, 1'b1, 32'hf800_0000, 6'h0);
    acc(3'b010, 1'b0, 1'b1, 32'hf800_0000, 6'h0);
    chk("load fault", 32'h0, 32'(storeFault));
    chk("irq masked", 32'h0, 32'(irq));
    rd(8'h1c, 32'h1);
    wr(8'h18, 32'h0);
    nop();
    acc(3'b001, 1'b0, 1'b1, 32'hf800_0000, 6'h0);
    chk("fault off", 32'h0, 32'(storeFault));
    $display("test user fault done");
    wr(8'h0c, 32'hffff_ffff);
    nop();
    acc(3'b100, 1'b1, 1'b0, 32'h2800_0000, 6'h0);
    chk("spec fetch", 32'h0, {fetchIssue, prefetchEnable});
    acc(3'b100, 1'b0, 1'b1, 32'h2800_0000, 6'h0);
    chk("late fetch", 32'h2, {fetchIssue, prefetchEnable});
    acc(3'b010, 1'b1, 1'b1, 32'h2800_0000, 6'h0);
    chk("spec load", 32'h0, 32'(loadIssue));
    wr(8'h0c, 32'h0);
    nop();
    acc(3'b100, 1'b1, 1'b0, 32'h2800_0000, 6'h0);
    chk("free fetch", 32'h3, {fetchIssue, prefetchEnable});
    acc(3'b010, 1'b1, 1'b1, 32'h2800_0000, 6'h0);
    chk("free load", 32'h1, 32'(loadIssue));
    // Held guarded fetch leaves its flag beside the earlier store fault
    rd(8'h1c, 32'h5);
    nop();
    $display("test guarded done");
    acc(3'b000, 1'b0, 1'b1, 32'h0, 6'h0);
    repeat (3) @(posedge sys_clk);
    end_of_test();
  end
endmodule
bind sar_resolver sar_props u_props (.*);
